// ### card_port_defines.vh
// Constants for the card interface host port
`ifndef CARD_PORT_DEFINES_VH
`define CARD_PORT_DEFINES_VH
`define CP_REG_SLOT_SEL 8'h48
`define CP_REG_GEN_IRQ 8'h49
`define CP_REG_SPEED 8'h4A
`define CP_REG_CTRL_WR 8'h40
`define CP_REG_STATUS 8'h41
`define CP_REG_WINDOW 8'h42
`define CP_SPEED_RST 8'h44
`define CP_SLOT_MIN 8'h01
`define CP_SLOT_MAX 8'h05
`define CP_GEN_AUX_BIT 5
`define CP_GEN_ALL_SLOTS 5'h1F
`define CP_ST_CARD_INSERTED_BIT 0
`define CP_ST_PRESENCE_CHANGE_FLAG 1
`define CP_ST_SUPPLY_DROP_FLAG 2
`define CP_ST_OVERLOAD_FAULT_FLAG 3
`define CP_ST_MUTE 4
`define CP_ST_EARLY 5
`define CP_ST_ACTIVE 6
`define CP_CTRL_ACT 0
`define CP_BASE_ADDR_0 4'h4
`define CP_BASE_ADDR_1 4'h5
`define CP_REG_GROUP 4'h4
`define CP_REG_WINDOW_RD 8'h43
`define CP_REG_SPEED_RD 8'h4B
`define CP_BITS_PER_BYTE 4'h8
`endif

// ### card_port.v
// Register port and event logic of a five-slot card interface
// ========================================================
`include "card_port_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module card_port #(
  parameter NSLOT = 5
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire i_address_strap_pin,
  input wire i_power_down_release,
  input wire i_auxiliary_alert_in,
  input wire i_slot_one_detect_in,
  input wire i_slot_two_detect_in,
  input wire [NSLOT-1:0] i_early_answer,
  input wire [NSLOT-1:0] i_mute_card,
  input wire [NSLOT-1:0] i_overload,
  input wire i_overheat,
  input wire i_supply_drop,
  output reg o_sda_oe_n,
  output reg o_host_alert_low,
  output reg o_shutdown,
  output reg [NSLOT-1:0] o_slot_active,
  output reg [7:0] o_edge_speed_control
);
// ========================================================
// Input synchronisers
reg [1:0] scl_s_ff, sda_s_ff, pd_s_ff, aux_s_ff, p1_s_ff, p2_s_ff;
reg scl_d_ff, sda_d_ff, aux_d_ff;
always @(posedge i_ref_clk) begin
  scl_s_ff <= {scl_s_ff[0], i_scl};
  sda_s_ff <= {sda_s_ff[0], i_sda};
  pd_s_ff <= {pd_s_ff[0], i_power_down_release};
  aux_s_ff <= {aux_s_ff[0], i_auxiliary_alert_in};
  p1_s_ff <= {p1_s_ff[0], i_slot_one_detect_in};
  p2_s_ff <= {p2_s_ff[0], i_slot_two_detect_in};
  scl_d_ff <= scl_s_ff[1];
  sda_d_ff <= sda_s_ff[1];
  aux_d_ff <= aux_s_ff[1];
end
wire scl = scl_s_ff[1];
wire sda = sda_s_ff[1];
wire scl_rise = scl & ~scl_d_ff;
wire scl_fall = ~scl & scl_d_ff;
wire start_c = scl & scl_d_ff & sda_d_ff & ~sda;
wire stop_c = scl & scl_d_ff & ~sda_d_ff & sda;
// Sampled at 5 ns, far faster than a 400 kHz bus
// ========================================================
// Shutdown: power_down_release low holds the register reset
wire sd = ~pd_s_ff[1];
wire regs_rst = i_rst | sd;
reg sd_d_ff;
always @(posedge i_ref_clk) begin
  if (i_rst) begin
    sd_d_ff <= 1'b0;
    o_shutdown <= 1'b1;
  end else begin
    sd_d_ff <= sd;
    o_shutdown <= sd;
  end
end
wire sd_exit = sd_d_ff & ~sd;
// ========================================================
// Serial target state machine
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_AACK = 3'h2;
localparam ST_WDATA = 3'h3;
localparam ST_RDATA = 3'h4;
localparam ST_DACK = 3'h5;
localparam ST_WAIT = 3'h6;
reg [2:0] st_ff;
reg [3:0] bit_ff;
reg [7:0] sh_ff;
reg rd_ff;
reg [6:0] addr_ff;
reg wr_pulse_ff;
reg [7:0] wdata_ff;
// Strap picks the target address set
reg p_strap_ff;
reg [1:0] strap_s_ff;
wire [3:0] base_addr = p_strap_ff ? `CP_BASE_ADDR_1 : `CP_BASE_ADDR_0;
always @(posedge i_ref_clk) begin
  strap_s_ff <= {strap_s_ff[0], i_address_strap_pin};
  if (i_rst)
    p_strap_ff <= 1'b0;
  else
    p_strap_ff <= strap_s_ff[1];
end
reg [7:0] rdata;
always @(posedge i_ref_clk) begin
  if (i_rst | sd) begin
    st_ff <= ST_IDLE;
    bit_ff <= 4'h0;
    sh_ff <= 8'h00;
    rd_ff <= 1'b0;
    o_sda_oe_n <= 1'b1;
    wr_pulse_ff <= 1'b0;
    wdata_ff <= 8'h00;
    addr_ff <= 7'h00;
  end else begin
    wr_pulse_ff <= 1'b0;
    if (start_c) begin
      st_ff <= ST_ADDR;
      bit_ff <= 4'h0;
      o_sda_oe_n <= 1'b1;
    end else if (stop_c) begin
      st_ff <= ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else begin
      case (st_ff)
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda};
            bit_ff <= bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == `CP_BITS_PER_BYTE) begin
            bit_ff <= 4'h0;
            if (st_ff == ST_ADDR) begin
              if (sh_ff[7:4] == base_addr) begin
                o_sda_oe_n <= 1'b0;
                rd_ff <= sh_ff[0];
                st_ff <= ST_AACK;
              end else
                st_ff <= ST_IDLE;
            end else begin
              o_sda_oe_n <= 1'b0;
              wdata_ff <= sh_ff;
              wr_pulse_ff <= 1'b1;
              st_ff <= ST_DACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rd_ff) begin
              sh_ff <= rdata;
              o_sda_oe_n <= rdata[7];
              bit_ff <= 4'h1;
              st_ff <= ST_RDATA;
            end else begin
              o_sda_oe_n <= 1'b1;
              st_ff <= ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_ff == `CP_BITS_PER_BYTE) begin
              o_sda_oe_n <= 1'b1;
              st_ff <= ST_WAIT; // Host ack not checked
            end else begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              o_sda_oe_n <= sh_ff[6];
              bit_ff <= bit_ff + 4'h1;
            end
          end
        end
        ST_DACK: begin
          if (scl_fall) begin
            o_sda_oe_n <= 1'b1;
            st_ff <= ST_WAIT;
          end
        end
        ST_WAIT: st_ff <= ST_WAIT;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
end
// ========================================================
// Registers
reg [7:0] slot_sel_ff;
reg [7:0] ctrl_ff [0:NSLOT-1];
reg [7:0] clkdiv_ff [0:NSLOT-1];
reg [NSLOT-1:0] presence_change_flag_ff, supply_drop_flag_ff, overload_fault_flag_ff, mute_ff, early_ff;
reg [1:0] card_inserted_bit_ff;
reg aux_irq_ff;
// Register index latched from every address byte, matching or not
reg [7:0] sel_reg_ff;
wire [7:0] wsel_addr = sel_reg_ff;
always @(posedge i_ref_clk) begin
  if (regs_rst)
    sel_reg_ff <= `CP_REG_SLOT_SEL;
  else if (st_ff == ST_ADDR && scl_fall && bit_ff == `CP_BITS_PER_BYTE)
    sel_reg_ff <= reg_sel_of(sh_ff);
end
function valid_slot;
  input [7:0] v;
  begin
    valid_slot = (v >= `CP_SLOT_MIN) && (v <= `CP_SLOT_MAX);
  end
endfunction
wire sel_ok = valid_slot(slot_sel_ff);
wire [2:0] sidx = slot_sel_ff[2:0] - 3'h1;
wire [7:0] gen_irq = {2'b00, aux_irq_ff, (presence_change_flag_ff | supply_drop_flag_ff | overload_fault_flag_ff |
  mute_ff | early_ff)};
wire [NSLOT-1:0] card_inserted_bit_old = {{(NSLOT-2){1'b0}}, card_inserted_bit_ff};
genvar g;
wire [7:0] slot_status [0:NSLOT-1];
generate
  for (g = 0; g < NSLOT; g = g + 1) begin : g_st
    assign slot_status[g] = {1'b0, o_slot_active[g], early_ff[g], mute_ff[g],
      overload_fault_flag_ff[g], supply_drop_flag_ff[g], presence_change_flag_ff[g], card_inserted_bit_old[g]};
  end
endgenerate
always @* begin
  rdata = 8'h00;
  case (wsel_addr)
    `CP_REG_GEN_IRQ: rdata = gen_irq;
    `CP_REG_SPEED_RD: rdata = o_edge_speed_control;
    `CP_REG_STATUS: rdata = sel_ok ? slot_status[sidx] : 8'h00;
    `CP_REG_WINDOW_RD: rdata = sel_ok ? clkdiv_ff[sidx] : 8'h00;
    default: rdata = 8'h00; // Control reads as zero
  endcase
end
// Address byte low nibble, R/W included, gives the register
function [7:0] reg_sel_of;
  input [7:0] a;
  begin
    reg_sel_of = {`CP_REG_GROUP, a[3:0]};
  end
endfunction
integer k;
always @(posedge i_ref_clk) begin
  if (regs_rst) begin
    slot_sel_ff <= 8'h00;
    o_edge_speed_control <= `CP_SPEED_RST;
    for (k = 0; k < NSLOT; k = k + 1) begin
      ctrl_ff[k] <= 8'h00;
      clkdiv_ff[k] <= 8'h00;
    end
  end else if (wr_pulse_ff) begin
    case (wsel_addr)
      `CP_REG_SLOT_SEL: slot_sel_ff <= wdata_ff;
      // Low nibble slot one, high nibble slots two to five
      `CP_REG_SPEED: o_edge_speed_control <= wdata_ff;
      `CP_REG_CTRL_WR: if (sel_ok) ctrl_ff[sidx] <= wdata_ff;
      `CP_REG_WINDOW: if (sel_ok) clkdiv_ff[sidx] <= wdata_ff;
      default: slot_sel_ff <= slot_sel_ff;
    endcase
  end
end
// ========================================================
// Events and slot activity
wire rd_status = (st_ff == ST_RDATA) && scl_fall &&
  bit_ff == `CP_BITS_PER_BYTE && wsel_addr == `CP_REG_STATUS && sel_ok;
wire [1:0] card_inserted_bit_now = {p2_s_ff[1], p1_s_ff[1]};
wire [NSLOT-1:0] card_inserted_bit_all = {{(NSLOT-2){1'b0}}, card_inserted_bit_now};
wire ctrl_wr = wr_pulse_ff && wsel_addr == `CP_REG_CTRL_WR && sel_ok;
integer j;
always @(posedge i_ref_clk) begin
  if (i_rst) begin
    presence_change_flag_ff <= {NSLOT{1'b0}};
    supply_drop_flag_ff <= {NSLOT{1'b0}};
    overload_fault_flag_ff <= {NSLOT{1'b0}};
    mute_ff <= {NSLOT{1'b0}};
    early_ff <= {NSLOT{1'b0}};
    card_inserted_bit_ff <= 2'b00;
    o_slot_active <= {NSLOT{1'b0}};
    aux_irq_ff <= 1'b0;
  end else begin
    card_inserted_bit_ff <= card_inserted_bit_now;
    // Auxiliary level follows external source after fall
    if (aux_d_ff & ~aux_s_ff[1])
      aux_irq_ff <= 1'b1;
    else if (aux_s_ff[1])
      aux_irq_ff <= 1'b0;
    for (j = 0; j < NSLOT; j = j + 1) begin
      // Read clears; a same-cycle event wins
      if (rd_status && sidx == j) begin
        presence_change_flag_ff[j] <= 1'b0;
        supply_drop_flag_ff[j] <= 1'b0;
        overload_fault_flag_ff[j] <= 1'b0;
        mute_ff[j] <= 1'b0;
        early_ff[j] <= 1'b0;
      end
      if (sd) begin
        // Only slot one presence watched
        o_slot_active[j] <= 1'b0;
        if (j == 0 && card_inserted_bit_now[0] != card_inserted_bit_ff[0])
          presence_change_flag_ff[0] <= 1'b1;
      end else begin
        if (ctrl_wr && sidx == j)
          o_slot_active[j] <= wdata_ff[`CP_CTRL_ACT];
        if (j < 2 && card_inserted_bit_all[j] != card_inserted_bit_old[j]) begin
          presence_change_flag_ff[j] <= 1'b1;
          if (!card_inserted_bit_all[j])
            o_slot_active[j] <= 1'b0;
        end
        if (i_early_answer[j]) early_ff[j] <= 1'b1;
        if (i_mute_card[j]) mute_ff[j] <= 1'b1;
        if (i_overload[j]) begin
          overload_fault_flag_ff[j] <= 1'b1;
          o_slot_active[j] <= 1'b0;
        end
        if (i_overheat) begin
          if (o_slot_active[j]) overload_fault_flag_ff[j] <= 1'b1;
          o_slot_active[j] <= 1'b0;
        end
        if (i_supply_drop || sd_exit) begin
          supply_drop_flag_ff[j] <= 1'b1;
          o_slot_active[j] <= 1'b0;
        end
      end
    end
    // Alert low while any cause pending
  end
end
always @(posedge i_ref_clk) begin
  if (i_rst)
    o_host_alert_low <= 1'b1;
  else
    o_host_alert_low <= ~(|gen_irq || sd_exit);
end
endmodule
`default_nettype wire

// ### card_port_properties.sv
// Assertion checker for the card interface host port
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker
module card_port_properties #(
  parameter NSLOT = 5
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire i_address_strap_pin,
  input wire i_power_down_release,
  input wire i_auxiliary_alert_in,
  input wire i_slot_one_detect_in,
  input wire i_slot_two_detect_in,
  input wire [NSLOT-1:0] i_early_answer,
  input wire [NSLOT-1:0] i_mute_card,
  input wire [NSLOT-1:0] i_overload,
  input wire i_overheat,
  input wire i_supply_drop,
  input wire o_sda_oe_n,
  input wire o_host_alert_low,
  input wire o_shutdown,
  input wire [NSLOT-1:0] o_slot_active,
  input wire [7:0] o_edge_speed_control
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  shutdown_entry_a: assert property (
    !i_power_down_release |-> ##[1:4] o_shutdown)
    else $error("shutdown not entered");
  shutdown_reset_a: assert property (
    o_shutdown && $past(o_shutdown) |-> o_edge_speed_control == 8'h44)
    else $error("speed register not held at default");
  exit_alert_a: assert property (
    $rose(i_power_down_release) |-> ##[1:6] (!o_shutdown && !o_host_alert_low))
    else $error("no alert on shutdown exit");
  overload_stop_a: assert property (
    i_overload[0] |-> ##[1:4] !o_slot_active[0])
    else $error("overloaded slot still active");
  overheat_stop_a: assert property (
    i_overheat |-> ##[1:4] (o_slot_active == 0))
    else $error("slots active after overheat");
  supply_stop_a: assert property (
    i_supply_drop |-> ##[1:4] (o_slot_active == 0 && !o_host_alert_low))
    else $error("supply drop not handled");
  aux_alert_a: assert property (
    $fell(i_auxiliary_alert_in) && !o_shutdown |-> ##[1:6] !o_host_alert_low)
    else $error("aux request gave no alert");
  removal_stop_a: assert property (
    $fell(i_slot_one_detect_in) && o_slot_active[0] |-> ##[1:8] !o_slot_active[0])
    else $error("removed card slot still active");
  quiet_shutdown_a: assert property (
    o_shutdown && $past(o_shutdown) |-> o_sda_oe_n)
    else $error("data line pulled in shutdown");
endmodule
bind card_port card_port_properties #(.NSLOT(NSLOT)) card_port_properties_i (.*);
`default_nettype wire

// ### host_master_model.sv
// Serial bus host master model for the card port
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host master
module host_master_model (
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda_pull
);
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // One bit, line sampled mid high phase
  task automatic bit_slot(input logic b, output logic s);
    o_sda_pull = ~b;
    #40 o_scl = 1'b1;
    #40 s = i_sda_line;
    #40 o_scl = 1'b0;
    #40;
  endtask

  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] ak,
                      output logic [7:0] q);
    logic s;
    o_sda_pull = 1'b1;
    #80 o_scl = 1'b0;
    for (int i = 7; i >= 0; i--) bit_slot(a[i], s);
    bit_slot(1'b1, s);
    ak[1] = ~s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], s);
      q[i] = s;
    end
    bit_slot(1'b1, s);
    ak[0] = ~s;
    o_sda_pull = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda_pull = 1'b0;
    #80;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the card interface host port
`include "card_port_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench top
module testbench;
  logic clk = 1'b0, rst = 1'b1, pdr = 1'b1, aux = 1'b1, det1 = 1'b0;
  logic [7:0] rq;
  logic heat = 1'b0, drop = 1'b0;
  logic [4:0] ovl = 5'h00;
  logic [1:0] acks = 2'h0;
  logic [7:0] d;
  logic [31:0] rng = 32'h61D3;
  wire scl, pull, oe_n, alert, sdn;
  wire [4:0] act;
  wire [7:0] spd;
  wire sda = ~pull & oe_n;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  logic [10:0] exq[$];
  event obs;

  card_port #(.NSLOT(5)) card_port_i (.i_ref_clk(clk), .i_rst(rst),
    .i_scl(scl), .i_sda(sda), .i_address_strap_pin(1'b0),
    .i_power_down_release(pdr), .i_auxiliary_alert_in(aux),
    .i_slot_one_detect_in(det1), .i_slot_two_detect_in(1'b0),
    .i_early_answer(5'h00), .i_mute_card(5'h00), .i_overload(ovl),
    .i_overheat(heat), .i_supply_drop(drop), .o_sda_oe_n(oe_n),
    .o_host_alert_low(alert), .o_shutdown(sdn), .o_slot_active(act),
    .o_edge_speed_control(spd));
  host_master_model host_master_model_i (.i_sda_line(sda), .o_scl(scl),
    .o_sda_pull(pull));

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task note(input logic [2:0] sel, input logic [7:0] v);
    exq.push_back({sel, v});
    ->obs;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    host_master_model_i.xfer(a, v, acks, rq);
    tick(2);
    note(3'h4, 8'h03);
  endtask

  // Host releases data and never acknowledges it
  task rd(input logic [7:0] a, input logic [7:0] v);
    host_master_model_i.xfer(a, 8'hFF, acks, rq);
    tick(2);
    note(3'h4, 8'h02);
    note(3'h5, v);
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Oldest note against the selected output
  initial begin : watch
    logic [10:0] e;
    logic [7:0] got;
    forever begin
      @(obs);
      while (exq.size() > 0) begin
        e = exq.pop_front();
        case (e[10:8])
          3'h0: got = spd;
          3'h1: got = {3'h0, act};
          3'h2: got = {7'h00, alert};
          3'h3: got = {7'h00, sdn};
          3'h5: got = rq;
          default: got = {6'h00, acks};
        endcase
        n_checks++;
        if (got !== e[7:0]) begin
          n_mismatch++;
          $display("[FAIL] t=%0t exp=%h got=%h", $time, e[7:0], got);
        end
      end
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    tick(6);
    rst = 1'b0;
    tick(6);
    note(3'h0, 8'h44);
    note(3'h3, 8'h00);
    note(3'h2, 8'h01);
    $display("reset test done");
    aux = 1'b0;
    tick(8);
    note(3'h2, 8'h00);
    aux = 1'b1;
    $display("aux test done");
    d = rnd();
    wr(`CP_REG_SPEED, d);
    note(3'h0, d);
    rd(`CP_REG_SPEED_RD, d);
    wr(`CP_REG_SLOT_SEL, `CP_SLOT_MIN);
    det1 = 1'b1;
    tick(4);
    $display("write test done");
    // Activate, then overload, overheat, supply drop, removal
    for (int k = 0; k < 4; k++) begin
      wr(`CP_REG_CTRL_WR, 8'h01);
      note(3'h1, 8'h01);
      ovl[0] = (k == 0);
      heat = (k == 1);
      drop = (k == 2);
      det1 = (k != 3);
      tick(1);
      ovl = 5'h00;
      heat = 1'b0;
      drop = 1'b0;
      tick(10);
      note(3'h1, 8'h00);
    end
    $display("fault test done");
    pdr = 1'b0;
    tick(8);
    note(3'h3, 8'h01);
    pdr = 1'b1;
    tick(10);
    note(3'h3, 8'h00);
    note(3'h2, 8'h00);
    note(3'h0, 8'h44);
    rd(`CP_REG_GEN_IRQ, `CP_GEN_ALL_SLOTS);
    $display("shutdown test done");
    tick(2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
